// [pstr_pkg.sv]
// Shared constants and carriers for the position status and retention block.
// Assumes one control clock and static settings.
package pstr_pkg;

    // ************************************************************
    // Output terminal function codes
    // ************************************************************
    localparam logic [7:0] PSTR_FN_TRAVEL_POS  = 8'h26; // 38
    localparam logic [7:0] PSTR_FN_TRAVEL_NEG  = 8'h8a; // 138
    localparam logic [7:0] PSTR_FN_ROUGH_POS   = 8'h3e; // 62
    localparam logic [7:0] PSTR_FN_ROUGH_NEG   = 8'ha2; // 162
    localparam logic [7:0] PSTR_FN_DETECT_POS  = 8'h3c; // 60
    localparam logic [7:0] PSTR_FN_DETECT_NEG  = 8'ha0; // 160
    localparam int         PSTR_NUM_TERMS      = 7;     // Output terminal selectors

    // ************************************************************
    // Detection and retention settings
    // ************************************************************
    localparam logic [1:0]  PSTR_SIDE_BOTH     = 2'h0;
    localparam logic [1:0]  PSTR_SIDE_PLUS     = 2'h1;
    localparam logic [1:0]  PSTR_SIDE_MINUS    = 2'h2;
    localparam logic [13:0] PSTR_RET_ALIGN     = 14'h0001; // 1
    localparam logic [13:0] PSTR_RET_HOLD      = 14'h0002; // 2
    localparam logic [13:0] PSTR_RET_ALIGN_NV  = 14'h000b; // 11
    localparam logic [13:0] PSTR_RET_HOLD_NV   = 14'h000c; // 12
    localparam logic [13:0] PSTR_RET_OFF       = 14'h270f; // 9999
    localparam logic [63:0] PSTR_DIGIT_SCALE   = 64'h0000_0000_0000_2710; // 10000
    localparam logic signed [63:0] PSTR_STORE_MIN = 64'shffff_ffff_8000_0000;
    localparam logic signed [63:0] PSTR_STORE_MAX = 64'sh0000_0000_7fff_ffff;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int PSTR_CLK_HZ        = 10_000_000;
    localparam int PSTR_NV_WRITE_MS   = 1000;      // One second write time
    localparam longint PSTR_NV_WRITE_CYC = longint'(PSTR_CLK_HZ) * PSTR_NV_WRITE_MS / 1000;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic signed [63:0] cmd;     // Position command
        logic signed [63:0] cur;     // Current position
        logic signed [63:0] droop;   // Droop count
        logic               homed;   // Homing complete
    } pstr_pos_t;

    typedef enum logic [1:0] {
        PSTR_NV_IDLE  = 2'b00,
        PSTR_NV_WRITE = 2'b01,
        PSTR_NV_DONE  = 2'b10
    } pstr_nv_state_t;

endpackage : pstr_pkg

// [pstr_core.sv]
// Position status flags, terminal mapping and position data retention.
// Assumes synchronous inputs, settings changed only while stopped,
// and an external store that survives resets.
`timescale 1ns/1ns

module pstr_core #(
    parameter longint NV_WRITE_CYC = pstr_pkg::PSTR_NV_WRITE_CYC
) (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic signed [63:0]  target_pos,        // Before gearing
    input  wire logic signed [63:0]  cmd_pos,           // Before gearing
    input  wire logic signed [63:0]  cur_pos,           // Before gearing
    input  wire logic signed [63:0]  cmd_pos_geared,    // After gearing
    input  wire logic signed [63:0]  cur_pos_geared,    // After gearing
    input  wire logic                pos_cmd_active,    // Command operation running
    input  wire logic                homing_done_in,    // Homing complete from homing logic
    input  wire logic [15:0]         in_position_width,
    input  wire logic [15:0]         rough_match_range,
    input  wire logic [13:0]         detect_lower_digits,
    input  wire logic [13:0]         detect_upper_digits,
    input  wire logic [1:0]          detect_side_select,
    input  wire logic [15:0]         detect_hysteresis_width,
    input  wire logic [13:0]         retention_select,
    input  wire logic [15:0]         gear_numerator,
    input  wire logic [15:0]         gear_denominator,
    input  wire logic [7:0]          control_method_select,
    input  wire logic                cap_life_measure,  // Pulse
    input  wire logic                motor_switch,      // Pulse
    input  wire logic                protective_trip,   // Pulse
    input  wire logic                servo_on_input,
    input  wire logic [7:0]          out_func_sel [pstr_pkg::PSTR_NUM_TERMS],
    input  wire pstr_pkg::pstr_pos_t nv_image,          // Stored image
    input  wire logic                nv_valid,          // Stored image valid
    input  wire logic                nv_busy,           // Write was in progress
    output logic [6:0]               out_terminals,
    output logic                     travel_done_flag,
    output logic                     in_position_flag,
    output logic                     pos_cmd_busy_flag,
    output logic                     rough_match_flag,
    output logic                     pos_detect_flag,
    output logic                     homing_done_flag,
    output pstr_pkg::pstr_pos_t      held_q_out,        // Held position data
    output logic                     held_valid,
    output logic                     restore_pulse,     // Restored data ready
    output pstr_pkg::pstr_pos_t      nv_wr_image,
    output logic                     nv_wr_valid,
    output logic                     nv_wr_busy,
    output logic                     excess_position_fault
);

    // ************************************************************
    // Helpers
    // ************************************************************
    // Terminal level for a flag given a function code pair
    function automatic logic term_map(input logic [7:0] sel, input logic [7:0] pos,
                                      input logic [7:0] neg, input logic flag);
        term_map = (sel == pos) ? flag : ((sel == neg) ? ~flag : 1'b0);
    endfunction

    // Settings 11 and 12 use nonvolatile storage
    function automatic logic is_nv(input logic [13:0] s);
        is_nv = (s == pstr_pkg::PSTR_RET_ALIGN_NV) || (s == pstr_pkg::PSTR_RET_HOLD_NV);
    endfunction

    // Settings 1 and 11 align the command to the current position
    function automatic logic is_align(input logic [13:0] s);
        is_align = (s == pstr_pkg::PSTR_RET_ALIGN) || (s == pstr_pkg::PSTR_RET_ALIGN_NV);
    endfunction

    // Fits the storable 32-bit signed range
    function automatic logic in_range(input logic signed [63:0] v);
        in_range = (v >= pstr_pkg::PSTR_STORE_MIN) && (v <= pstr_pkg::PSTR_STORE_MAX);
    endfunction

    // ************************************************************
    // Status flags
    // ************************************************************
    logic signed [63:0] droop_w;      // Command minus current, after gearing
    logic signed [63:0] remain_w;     // Target minus command, before gearing
    logic signed [63:0] judge_w;      // Detection judgment value
    logic signed [63:0] hyst_w;       // Release level below the judgment value
    logic signed [63:0] side_w;       // Position as judged on the chosen side
    logic               inpos_d, busy_d, travel_d, rough_d, detect_d;
    logic               inpos_q, busy_q, travel_q, rough_q, detect_q;
    logic [6:0]         term_d, term_q;

    // Compare positions with thresholds each cycle
    always_comb begin
        droop_w  = cmd_pos_geared - cur_pos_geared;
        remain_w = target_pos - cmd_pos;
        judge_w  = $signed(64'(detect_upper_digits) * pstr_pkg::PSTR_DIGIT_SCALE
                   + 64'(detect_lower_digits));
        hyst_w   = judge_w - $signed(64'(detect_hysteresis_width));
        inpos_d  = droop_w <= $signed(64'(in_position_width));
        busy_d   = pos_cmd_active;
        travel_d = inpos_q && !busy_q;
        rough_d  = remain_w <= $signed(64'(rough_match_range));

        // Plus judges position, minus its negation, both its magnitude
        case (detect_side_select)
            pstr_pkg::PSTR_SIDE_PLUS:  side_w = cur_pos;
            pstr_pkg::PSTR_SIDE_MINUS: side_w = -cur_pos;
            default:                   side_w = (cur_pos < 64'sh0) ? -cur_pos : cur_pos;
        endcase

        // Set past the judgment value, release only below the hysteresis band
        detect_d = detect_q;
        if (side_w > judge_w) begin
            detect_d = 1'b1;
        end else if (side_w <= hyst_w) begin
            detect_d = 1'b0;
        end

        // Map flags onto the assignable terminals
        for (int i = 0; i < pstr_pkg::PSTR_NUM_TERMS; i++) begin
            term_d[i] = term_map(out_func_sel[i], pstr_pkg::PSTR_FN_TRAVEL_POS,
                                 pstr_pkg::PSTR_FN_TRAVEL_NEG, travel_q)
                      | term_map(out_func_sel[i], pstr_pkg::PSTR_FN_ROUGH_POS,
                                 pstr_pkg::PSTR_FN_ROUGH_NEG, rough_q)
                      | term_map(out_func_sel[i], pstr_pkg::PSTR_FN_DETECT_POS,
                                 pstr_pkg::PSTR_FN_DETECT_NEG, detect_q);
        end
    end

    // Register status flags
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            inpos_q  <= 1'b0;
            busy_q   <= 1'b0;
            travel_q <= 1'b0;
            rough_q  <= 1'b0;
            detect_q <= 1'b0;
            term_q   <= 7'h00;
        end else begin
            inpos_q  <= inpos_d;
            busy_q   <= busy_d;
            travel_q <= travel_d;
            rough_q  <= rough_d;
            detect_q <= detect_d;
            term_q   <= term_d;
        end
    end

    // ************************************************************
    // Retention and nonvolatile write
    // ************************************************************
    pstr_pkg::pstr_pos_t     held_d, held_q, wr_img_d, wr_img_q;
    pstr_pkg::pstr_nv_state_t nv_d, nv_q;
    logic [31:0]  cnt_d, cnt_q;
    logic         hvalid_d, hvalid_q, wrv_d, wrv_q, fault_d, fault_q;
    logic         servo_q, first_d, first_q, rest_d, rest_q;
    logic [13:0]  ret_q;
    logic [15:0]  num_q, den_q;
    logic [7:0]   meth_q;
    logic         clear_evt;

    // Capture, clear, restore and write sequencing
    always_comb begin
        held_d   = held_q;
        hvalid_d = hvalid_q;
        wr_img_d = wr_img_q;
        wrv_d    = wrv_q;
        nv_d     = nv_q;
        cnt_d    = cnt_q;
        fault_d  = fault_q;
        first_d  = 1'b0;
        rest_d   = 1'b0;

        clear_evt = (!first_q && ((retention_select != ret_q) || (gear_numerator != num_q)
                    || (gear_denominator != den_q) || (control_method_select != meth_q)))
                    || cap_life_measure || motor_switch || protective_trip;
        if (first_q) begin
            // First cycle after reset: restore or report failed write
            if (nv_busy) fault_d = 1'b1;
            else if (is_nv(retention_select) && nv_valid) begin
                held_d   = nv_image;
                hvalid_d = 1'b1;
                rest_d   = 1'b1;
            end
        end
        if (servo_q && !servo_on_input) begin
            if (retention_select == pstr_pkg::PSTR_RET_OFF) begin
                held_d   = '0;
                hvalid_d = 1'b0;
            end else begin
                held_d.cmd   = is_align(retention_select) ? cur_pos_geared : cmd_pos_geared;
                held_d.cur   = cur_pos_geared;
                held_d.droop = is_align(retention_select) ? 64'sh0 : droop_w;
                held_d.homed = homing_done_in;
                hvalid_d     = 1'b1;
            end

            if (is_nv(retention_select)) begin
                nv_d  = pstr_pkg::PSTR_NV_WRITE;
                cnt_d = '0;
                if (in_range(held_d.cmd) && in_range(held_d.cur)
                    && in_range(held_d.droop)) begin
                    wr_img_d = held_d;
                    wrv_d    = 1'b1;
                end else begin
                    wr_img_d = '0;
                    wrv_d    = 1'b0;
                end
            end
        end else if (nv_q == pstr_pkg::PSTR_NV_WRITE) begin
            cnt_d = cnt_q + 32'h0000_0001;
            if (64'(cnt_q) >= 64'(NV_WRITE_CYC - 1)) nv_d = pstr_pkg::PSTR_NV_DONE;
        end else if (nv_q == pstr_pkg::PSTR_NV_DONE) begin
            nv_d = pstr_pkg::PSTR_NV_IDLE;
        end
        if (clear_evt) begin
            held_d   = '0;
            hvalid_d = 1'b0;
            wr_img_d = '0;
            wrv_d    = 1'b0;
        end
    end

    // Register retention state
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            held_q   <= '0;
            hvalid_q <= 1'b0;
            wr_img_q <= '0;
            wrv_q    <= 1'b0;
            nv_q     <= pstr_pkg::PSTR_NV_IDLE;
            cnt_q    <= 32'h0000_0000;
            fault_q  <= 1'b0;
            first_q  <= 1'b1;
            rest_q   <= 1'b0;
            servo_q  <= 1'b0;
            ret_q    <= pstr_pkg::PSTR_RET_OFF;
            num_q    <= 16'h0001;
            den_q    <= 16'h0001;
            meth_q   <= 8'h00;
        end else begin
            held_q   <= held_d;
            hvalid_q <= hvalid_d;
            wr_img_q <= wr_img_d;
            wrv_q    <= wrv_d;
            nv_q     <= nv_d;
            cnt_q    <= cnt_d;
            fault_q  <= fault_d;
            first_q  <= first_d;
            rest_q   <= rest_d;
            servo_q  <= servo_on_input;
            ret_q    <= retention_select;
            num_q    <= gear_numerator;
            den_q    <= gear_denominator;
            meth_q   <= control_method_select;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign out_terminals         = term_q;
    assign travel_done_flag      = travel_q;
    assign in_position_flag      = inpos_q;
    assign pos_cmd_busy_flag     = busy_q;
    assign rough_match_flag      = rough_q;
    assign pos_detect_flag       = detect_q;
    assign homing_done_flag      = held_q.homed;
    assign held_q_out            = held_q;
    assign held_valid            = hvalid_q;
    assign restore_pulse         = rest_q;
    assign nv_wr_image           = wr_img_q;
    assign nv_wr_valid           = wrv_q;
    assign nv_wr_busy            = nv_q[0];  // Only the write state has bit 0 set
    assign excess_position_fault = fault_q;


endmodule // pstr_core

// [pstr_core_monitor.sv]
// Checker for pstr_core: flag timing, terminal codes and retention.
// Assumes binding into pstr_core.
`timescale 1ns/1ns
module pstr_core_monitor #(
    parameter longint NV_WRITE_CYC = pstr_pkg::PSTR_NV_WRITE_CYC
) (
    input wire logic               core_clk,
    input wire logic               reset,
    input wire logic signed [63:0] cur_pos,
    input wire logic               pos_cmd_active,
    input wire logic [13:0]        detect_lower_digits,
    input wire logic [13:0]        detect_upper_digits,
    input wire logic [1:0]         detect_side_select,
    input wire logic [15:0]        detect_hysteresis_width,
    input wire logic [13:0]        retention_select,
    input wire logic               protective_trip,
    input wire logic               servo_on_input,
    input wire logic [7:0]         out_func_sel [pstr_pkg::PSTR_NUM_TERMS],
    input wire logic [6:0]         out_terminals,
    input wire logic               travel_done_flag,
    input wire logic               in_position_flag,
    input wire logic               pos_cmd_busy_flag,
    input wire logic               rough_match_flag,
    input wire logic               pos_detect_flag,
    input wire logic               homing_done_flag,
    input wire logic               held_valid,
    input wire logic               nv_wr_busy,
    input wire logic               excess_position_fault
);
    // ************************************************************
    // Helper state
    // ************************************************************
    logic               up_q;         // High from the first edge after reset
    logic [31:0]        cnt_q;        // Edges the store write has stood
    logic signed [63:0] judge;        // Detection judgment value
    assign judge = $signed(64'(detect_upper_digits) * pstr_pkg::PSTR_DIGIT_SCALE)
                 + $signed(64'(detect_lower_digits));
    // Register helper values
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            up_q  <= 1'b0;
            cnt_q <= 32'h0;
        end else begin
            up_q  <= 1'b1;
            cnt_q <= nv_wr_busy ? cnt_q + 32'h1 : 32'h0;
        end
    end
    // Level a terminal should show for a function code
    function automatic logic term_of(logic [7:0] c, logic t, logic r, logic d);
        return (c == pstr_pkg::PSTR_FN_TRAVEL_POS & t) | (c == pstr_pkg::PSTR_FN_TRAVEL_NEG & !t)
             | (c == pstr_pkg::PSTR_FN_ROUGH_POS & r) | (c == pstr_pkg::PSTR_FN_ROUGH_NEG & !r)
             | (c == pstr_pkg::PSTR_FN_DETECT_POS & d) | (c == pstr_pkg::PSTR_FN_DETECT_NEG & !d);
    endfunction
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    // ************************************************************
    // Properties
    // ************************************************************
    property p_travel; up_q |-> travel_done_flag == ($past(in_position_flag) && !$past(pos_cmd_busy_flag)); endproperty
    a_travel: assert property (p_travel) else $error("travel done wrong");
    property p_busy; up_q |-> pos_cmd_busy_flag == $past(pos_cmd_active); endproperty
    a_busy: assert property (p_busy) else $error("busy flag wrong");
    property p_term(o, c);
        up_q |-> o == term_of(c, $past(travel_done_flag), $past(rough_match_flag), $past(pos_detect_flag));
    endproperty
    for (genvar i = 0; i < 7; i++) begin : g_term
        a_term: assert property (p_term(out_terminals[i], out_func_sel[i])) else $error("terminal wrong");
    end
    property p_set;
        up_q && $rose(pos_detect_flag) |-> ($past(detect_side_select) != pstr_pkg::PSTR_SIDE_MINUS
            && $past(cur_pos) > judge) || ($past(detect_side_select) != pstr_pkg::PSTR_SIDE_PLUS && -$past(cur_pos) > judge);
    endproperty
    a_set: assert property (p_set) else $error("detect set wrong");
    property p_rel;
        up_q && $fell(pos_detect_flag) && $past(detect_side_select) == pstr_pkg::PSTR_SIDE_PLUS
            |-> $past(cur_pos) <= judge - $signed(64'(detect_hysteresis_width));
    endproperty
    a_rel: assert property (p_rel) else $error("detect release early");
    property p_capture;
        up_q && $fell(servo_on_input) && !protective_trip && retention_select != pstr_pkg::PSTR_RET_OFF |-> ##[1:2] held_valid;
    endproperty
    a_capture: assert property (p_capture) else $error("no capture at servo off");
    property p_off; up_q && $fell(servo_on_input) && retention_select == pstr_pkg::PSTR_RET_OFF |=> !held_valid; endproperty
    a_off: assert property (p_off) else $error("data kept while disabled");
    property p_clear; protective_trip |=> !held_valid && !homing_done_flag; endproperty
    a_clear: assert property (p_clear) else $error("trip did not clear");
    property p_nvlen; $fell(nv_wr_busy) |-> longint'(cnt_q) == NV_WRITE_CYC; endproperty
    a_nvlen: assert property (p_nvlen) else $error("write window length wrong");
    property p_fault; excess_position_fault |=> excess_position_fault; endproperty
    a_fault: assert property (p_fault) else $error("fault not sticky");
    c_travel: cover property (up_q && $rose(travel_done_flag));
    c_write: cover property ($rose(nv_wr_busy));
    c_fault: cover property ($rose(excess_position_fault));
endmodule // pstr_core_monitor

// [pstr_host_model.sv]
// Host-side model: servo-on sequencing and the nonvolatile store.
// Assumes the store survives every reset.
`timescale 1ns/1ns
module pstr_host_model (
    input  wire logic                core_clk,
    input  wire logic                reset,
    input  wire logic                servo_req,        // Bench asks for servo on
    input  wire logic                travel_done_flag, // Motor stopped and locked
    input  wire pstr_pkg::pstr_pos_t nv_wr_image,
    input  wire logic                nv_wr_valid,
    input  wire logic                nv_wr_busy,
    output logic                     servo_on_input,
    output pstr_pkg::pstr_pos_t      nv_image,
    output logic                     nv_valid,
    output logic                     nv_busy
);
    // Start with servo off and an empty store
    initial begin
        servo_on_input = 1'b0;
        {nv_image, nv_valid, nv_busy} = '0;
    end
    // Servo goes off only once the motor has stopped and locked
    always @(posedge core_clk) begin
        if (servo_req) begin
            servo_on_input <= 1'b1;
        end else if (travel_done_flag === 1'b1) begin
            servo_on_input <= 1'b0;
        end
    end
    // Store takes the image only while a write runs; a reset freezes it
    always @(posedge core_clk) begin
        if (!reset && (nv_wr_busy || nv_busy)) begin
            {nv_image, nv_valid, nv_busy} <= {nv_wr_image, nv_wr_valid, nv_wr_busy};
        end
    end
endmodule // pstr_host_model

// [pstr_core_bench.sv]
// Self-checking bench for pstr_core: a flag table, then retention cases.
// Assumes all other files are compiled first.
`timescale 1ns/1ns
module pstr_core_bench;
    // Table row: stimulus beside expected {in_pos, busy, rough, detect}
    typedef struct {
        logic signed [63:0] diff, remain, cur;
        logic               act;
        logic [1:0]         side;
        logic [3:0]         exp;
    } pstr_row_t;
    localparam longint NV_CYC = 20; // Shortened store write time
    localparam logic [13:0] RETS [5] = '{14'h0001, 14'h0002, 14'h000b, 14'h000c, 14'h270f};
    pstr_row_t rows [8] = '{'{64'sh0, 64'sh0, 64'sh0, 1'b0, 2'h0, 4'ha},
        '{64'sh64, 64'sh32, 64'sh2716, 1'b0, 2'h0, 4'hb}, '{64'sh65, 64'sh33, 64'sh2710, 1'b1, 2'h0, 4'h5},
        '{-64'sh5, -64'sh3, 64'sh270b, 1'b0, 2'h0, 4'ha}, '{64'sh0, 64'sh64, -64'sh2716, 1'b1, 2'h0, 4'hd},
        '{64'sh0, 64'sh0, -64'sh2716, 1'b0, 2'h1, 4'ha}, '{64'sh0, 64'sh0, -64'sh2716, 1'b0, 2'h2, 4'hb},
        '{64'sh0, 64'sh0, 64'sh2716, 1'b0, 2'h2, 4'ha}};
    logic                core_clk = 1'b0;
    logic                reset = 1'b1;
    logic signed [63:0]  target_pos, cmd_pos, cur_pos, cmd_pos_geared, cur_pos_geared;
    logic                pos_cmd_active, homing_done_in, cap_life_measure, motor_switch;
    logic                protective_trip, servo_req, servo_on_input, seen_restore;
    logic [15:0]         in_position_width, rough_match_range, detect_hysteresis_width;
    logic [15:0]         gear_numerator, gear_denominator;
    logic [13:0]         detect_lower_digits, detect_upper_digits, retention_select;
    logic [1:0]          detect_side_select;
    logic [7:0]          control_method_select;
    logic [7:0]          out_func_sel [pstr_pkg::PSTR_NUM_TERMS];
    pstr_pkg::pstr_pos_t nv_image, held_q_out, nv_wr_image;
    logic                nv_valid, nv_busy, travel_done_flag, in_position_flag, pos_cmd_busy_flag;
    logic                rough_match_flag, pos_detect_flag, homing_done_flag, held_valid;
    logic                restore_pulse, nv_wr_valid, nv_wr_busy, excess_position_fault;
    logic [6:0]          out_terminals;
    int                  num_errors = 0, num_checks = 0, cyc = 0;
    pstr_core #(.NV_WRITE_CYC(NV_CYC)) i_dut (.*);
    pstr_host_model i_host (.*);
    always #50 core_clk = ~core_clk;
    // Cycle ceiling and restore-pulse catcher
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (reset) seen_restore <= 1'b0;
        else if (restore_pulse === 1'b1) seen_restore <= 1'b1;
        if (cyc == 3000) begin
            num_errors++;
            complete_run();
        end
    end
    task automatic chk_bit(input logic got, input logic exp, input string what);
        chk_vec(64'(got), 64'(exp), what);
    endtask
    task automatic chk_vec(input logic [63:0] got, input logic [63:0] exp, input string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask
    // Drive one row and let the flag pipeline settle
    task automatic apply(input pstr_row_t r);
        @(posedge core_clk);
        {cur_pos, cur_pos_geared, cmd_pos_geared} <= {r.cur, r.cur, r.cur + r.diff};
        {target_pos, cmd_pos} <= {r.cur, r.cur - r.remain};
        {pos_cmd_active, detect_side_select} <= {r.act, r.side};
        repeat (4) @(negedge core_clk);
    endtask
    task automatic servo(input logic on);
        @(posedge core_clk);
        servo_req <= on;
        for (int n = 0; n < 50 && servo_on_input !== on; n++) @(posedge core_clk);
        repeat (3) @(negedge core_clk);
    endtask
    // Stop, pick a retention setting, then servo on and off
    task automatic capture(input logic [13:0] ret, input logic signed [63:0] cur);
        apply('{64'sh0, 64'sh7, cur, 1'b0, 2'h0, 4'h0});
        @(posedge core_clk);
        retention_select <= ret; // Changed only while stopped
        servo(1'b1);
        servo(1'b0);
    endtask
    task automatic wait_store;
        for (int n = 0; n < 60 && nv_wr_busy !== 1'b0; n++) @(negedge core_clk);
    endtask
    task automatic do_reset;
        @(posedge core_clk);
        reset <= 1'b1;
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        repeat (4) @(negedge core_clk);
    endtask
    task automatic complete_run;
        $display("Counts: %0d checks, %0d errors", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    initial begin
        logic [3:0] e;
        logic       t;
        {target_pos, cmd_pos, cur_pos, cmd_pos_geared, cur_pos_geared} = '0;
        {pos_cmd_active, homing_done_in, cap_life_measure, motor_switch, protective_trip} = 5'h08;
        {servo_req, detect_side_select} = 3'h0;
        {in_position_width, rough_match_range, detect_hysteresis_width} = {16'h0064, 16'h0032, 16'h000a};
        {detect_lower_digits, detect_upper_digits, retention_select} = {14'h0005, 14'h0001, 14'h270f};
        {gear_numerator, gear_denominator} = {16'h0001, 16'h0001};
        control_method_select = 8'h03; // Method suited to command by communication
        out_func_sel = '{8'h26, 8'h8a, 8'h3e, 8'ha2, 8'h3c, 8'ha0, 8'h00};
        repeat (6) @(posedge core_clk);
        reset <= 1'b0;
        foreach (rows[i]) begin
            apply(rows[i]);
            e = rows[i].exp;
            t = e[3] & ~e[2];
            chk_bit(in_position_flag, e[3], "in position");
            chk_bit(pos_cmd_busy_flag, e[2], "busy");
            chk_bit(rough_match_flag, e[1], "rough match");
            chk_bit(pos_detect_flag, e[0], "position detect");
            chk_bit(travel_done_flag, t, "travel done");
            chk_vec(64'(out_terminals), {58'h0, ~e[0], e[0], ~e[1], e[1], ~t, t}, "terminals");
        end
        for (int i = 0; i < 5; i++) begin
            capture(RETS[i], 64'sh7b);
            chk_bit(held_valid, i < 4, "held data");
            chk_bit(homing_done_flag, i < 4, "homing held");
            chk_bit(nv_wr_busy, i == 2 || i == 3, "store write");
            if (i == 0 || i == 2) begin
                chk_vec(held_q_out.droop, 64'h0, "droop cleared");
            end
            wait_store();
            @(posedge core_clk);
            {protective_trip, motor_switch, cap_life_measure} <= 3'h1 << (i % 3);
            @(posedge core_clk);
            {protective_trip, motor_switch, cap_life_measure} <= 3'h0;
            repeat (2) @(negedge core_clk);
            chk_bit(held_valid, 1'b0, "cleared by event");
        end
        capture(14'h000c, 64'sh7b);
        wait_store();
        do_reset();
        chk_bit(held_valid, 1'b1, "restored");
        chk_bit(seen_restore, 1'b1, "restore pulse");
        capture(14'h0002, 64'sh7b);
        do_reset();
        chk_bit(held_valid, 1'b0, "kept over reset");
        capture(14'h000c, 64'sh1_0000_0000);
        chk_bit(nv_wr_valid, 1'b0, "out of range stored");
        wait_store();
        capture(14'h000b, 64'sh7b);
        do_reset(); // Reset in mid-write on purpose
        chk_bit(excess_position_fault, 1'b1, "interrupted write");
        complete_run();
    end
endmodule // pstr_core_bench
bind pstr_core pstr_core_monitor #(.NV_WRITE_CYC(NV_WRITE_CYC)) i_mon (.*);
